// >>> bench/dote_engine_assertions.sv
`timescale 1ns/1ns
module dote_engine_assertions
  import dote_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controls
  input wire dote_cfg_t cfg,
  input wire logic underflow_clr,
  input wire logic [2*LINE_N-1:0] powerup_state,
  // Outputs
  input wire logic [LINE_N-1:0] line_out,
  input wire logic [LINE_N-1:0] line_oe,
  input wire logic output_start_trigger,
  input wire logic output_sample_clock_n,
  input wire logic running,
  input wire logic underflow
);
  // ----
  // Power-up decode
  // ----
  logic [LINE_N-1:0] oe_exp;
  logic [LINE_N-1:0] out_exp;
  wire dflt_delay = cfg.start_delay == START_DELAY_RST && cfg.tb_sel == TB_100M;
  always_comb begin
    for (int i = 0; i < LINE_N; i++) begin
      oe_exp[i] = powerup_state[2*i] | powerup_state[2*i+1];
      out_exp[i] = powerup_state[2*i+1];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence run_after_two;
    !running ##1 !running ##1 running;
  endsequence
  start_pulse_a: assert property (output_start_trigger |=> !output_start_trigger)
    else $error("start export wider than one cycle");
  start_delay_a: assert property (output_start_trigger && dflt_delay |-> run_after_two)
    else $error("first sample not two ticks after start");
  run_ignore_a: assert property (running |-> !output_start_trigger)
    else $error("start accepted while running");
  sclk_pulse_a: assert property (
    !output_sample_clock_n && cfg.divisor != DIVISOR_RST |=> output_sample_clock_n)
    else $error("sample clock export not a single low cycle");
  uflow_sticky_a: assert property (underflow && !underflow_clr |=> underflow)
    else $error("underflow dropped without clear");
  uflow_clr_a: assert property (
    underflow_clr && !running && !$past(running) |=> !underflow)
    else $error("underflow not cleared");
  uflow_cause_a: assert property ($rose(underflow) |-> $past(running))
    else $error("underflow raised outside a run");
  pu_hiz_a: assert property ($rose(rst_n) |-> line_oe == '0)
    else $error("lines driven during reset");
  pu_load_a: assert property (
    $rose(rst_n) |=> line_oe == oe_exp && line_out == out_exp)
    else $error("power-up states not applied");
endmodule // dote_engine_assertions

bind dote_engine dote_engine_assertions dote_engine_assertions_i (
  .clock(clock), .rst_n(rst_n), .cfg(cfg), .underflow_clr(underflow_clr),
  .powerup_state(powerup_state), .line_out(line_out), .line_oe(line_oe),
  .output_start_trigger(output_start_trigger),
  .output_sample_clock_n(output_sample_clock_n), .running(running),
  .underflow(underflow)
);

// >>> bench/dote_host_model.sv
`timescale 1ns/1ns
module dote_host_model
  import dote_pkg::*;
(
  // Clock
  input wire logic clock,
  // Sample stream
  output logic [DATA_W-1:0] sample_data,
  output logic sample_valid,
  input wire logic sample_ready
);
  // ----
  // Word delivery, held until taken
  // ----
  initial begin
    sample_data = '0;
    sample_valid = 1'b0;
  end
  task automatic send(input logic [DATA_W-1:0] w, input int gap);
    repeat (gap + 1) @(posedge clock);
    sample_data <= w;
    sample_valid <= 1'b1;
    @(negedge clock);
    while (sample_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    // Inverted after release so a stale word is never reused
    sample_data <= ~w;
    sample_valid <= 1'b0;
  endtask
endmodule // dote_host_model

// >>> bench/tb_dote_engine.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_dote_engine
  import dote_pkg::*;
;
  logic clock, rst_n, sw_start, sw_stop, underflow_clr, tie0, ana;
  dote_cfg_t cfg;
  logic [PFT_N-1:0] pft;
  logic [STB_N-1:0] stb;
  logic [2*LINE_N-1:0] powerup_state;
  logic [DATA_W-1:0] sample_data;
  logic sample_valid, sample_ready, start_x, sclk_n, running, underflow;
  logic [LINE_N-1:0] line_out, line_oe;
  int n_errors, checks, n_start;
  logic [DATA_W-1:0] smp_q[$], exp_q[$];

  dote_engine dote_engine_i (.clock(clock), .rst_n(rst_n), .cfg(cfg),
    .sw_start(sw_start), .sw_stop(sw_stop), .underflow_clr(underflow_clr),
    .programmable_function_terminal(pft), .system_trigger_bus_line(stb),
    .backplane_clk10(tie0), .analog_event(ana), .internal_clock(tie0),
    .internal_trigger(tie0), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .powerup_state(powerup_state), .line_out(line_out), .line_oe(line_oe),
    .output_start_trigger(start_x), .output_sample_clock_n(sclk_n),
    .running(running), .underflow(underflow));
  dote_host_model dote_host_model_i (.clock(clock), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready));

  // ----
  // Clock, monitor and helpers
  // ----
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(negedge clock) begin
    if (rst_n && sclk_n === 1'b0) smp_q.push_back(line_out);
    if (rst_n && start_x === 1'b1) n_start++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic cmd(input int k);
    @(posedge clock);
    case (k)
      0: sw_start <= 1'b1;
      1: sw_stop <= 1'b1;
      default: underflow_clr <= 1'b1;
    endcase
    @(posedge clock);
    {sw_start, sw_stop, underflow_clr} <= 3'h0;
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge clock);
    pft[k] <= v;
    cyc(8);
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 40 && running !== 1'b1; i++) @(posedge clock);
    for (i = 0; i < 2000 && running !== 1'b0; i++) @(posedge clock);
    cyc(4);
  endtask
  // Alternates prompt and slow delivery from the host side
  task automatic load(input int n, input logic [DATA_W-1:0] base);
    for (int k = 0; k < n; k++) begin
      dote_host_model_i.send(base + DATA_W'(k), (k % 2) * 3);
      exp_q.push_back(base + DATA_W'(k));
    end
  endtask
  task automatic check_q(input string nm);
    `CHK(nm, exp_q.size(), smp_q.size())
    for (int k = 0; k < exp_q.size() && k < smp_q.size(); k++) `CHK(nm, exp_q[k], smp_q[k])
    smp_q.delete();
    exp_q.delete();
    $display("test %s done", nm);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    n_errors++;
    conclude();
  end

  // ----
  // Tests
  // ----
  initial begin
    {rst_n, sw_start, sw_stop, underflow_clr, tie0, ana} = 6'h0;
    {pft, stb} = '0;
    cfg = '0;
    cfg.divisor = 16'h0003;
    cfg.start_delay = START_DELAY_RST;
    cfg.finite = 1'b1;
    cfg.sample_count = 32'h3;
    powerup_state = 64'h9;
    {n_errors, checks, n_start} = '0;
    cyc(5);
    @(negedge clock) `CHK("reset oe", 32'h0, line_oe)
    @(posedge clock) rst_n <= 1'b1;
    cyc(2);
    @(negedge clock) `CHK("powerup oe", 32'h3, line_oe)
    `CHK("powerup out", 32'h2, line_out)
    load(3, 32'ha5a50010);
    cmd(0);
    wait_run();
    check_q("soft start");
    `CHK("starts", 1, n_start)
    `CHK("no underflow", 1'b0, underflow)
    cfg.sample_count <= 32'h2;
    cmd(0);
    wait_run();
    `CHK("underflow", 1'b1, underflow)
    cmd(2);
    @(negedge clock) `CHK("underflow clr", 1'b0, underflow)
    smp_q.delete();
    $display("test underflow done");
    @(posedge clock);
    cfg.trig_sel <= TR_PFT;
    cfg.trig_line <= 4'h5;
    cfg.retrigger <= 1'b1;
    cfg.divisor <= 16'h000a;
    // Stopped engine is re-armed by software before hardware triggers count
    cmd(0);
    for (int f = 0; f < 2; f++) begin
      @(posedge clock);
      cfg.trig_falling <= f[0];
      pft[5] <= f[0];
      load(4, 32'h5a000000 + 32'(f) * 32'h10);
      n_start = 0;
      repeat (2) begin
        pin(5, !f[0]);
        pin(5, f[0]);
        pin(5, !f[0]);
        pin(5, f[0]);
        wait_run();
      end
      `CHK("retrigger starts", 2, n_start)
      check_q("retrigger");
    end
    @(posedge clock);
    cfg.trig_sel <= TR_ANALOG;
    {cfg.retrigger, cfg.trig_falling} <= 2'b00;
    cfg.sample_count <= 32'h1;
    load(1, 32'h0000a0a0);
    @(posedge clock) ana <= 1'b1;
    wait_run();
    check_q("analog start");
    @(posedge clock);
    cfg.trig_sel <= TR_NONE;
    {cfg.retrigger, cfg.finite} <= 2'b00;
    cfg.sc_sel <= SC_PFT;
    cfg.sc_line <= 4'h2;
    cfg.pause_sel <= TR_PFT;
    cfg.pause_line <= 4'h3;
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      {cfg.pause_low, cfg.sc_falling} <= {p[0], p[0]};
      pft[3] <= !p[0];
      load(2, 32'h3c000000 + 32'(p) * 32'h10);
      cmd(0);
      repeat (3) begin
        pin(2, 1'b1);
        pin(2, 1'b0);
      end
      pin(3, p[0]);
      repeat (2) begin
        pin(2, 1'b1);
        pin(2, 1'b0);
      end
      cmd(1);
      wait_run();
      check_q("pause");
    end
    @(posedge clock);
    cfg.sc_sel <= SC_ENGINE;
    cfg.pause_sel <= TR_NONE;
    cfg.finite <= 1'b1;
    cfg.sample_count <= 32'h5;
    load(2, 32'hc3c30000);
    @(posedge clock) cfg.retransmit <= 1'b1;
    for (int k = 0; k < 3; k++) exp_q.push_back(exp_q[k]);
    cmd(0);
    wait_run();
    check_q("retransmit");
    conclude();
  end
endmodule // tb_dote_engine

// >>> hw/dote_engine.sv
`timescale 1ns/1ns
// Operation
// - Sample edge with empty FIFO flags underflow
// - Update on chosen sample clock edge
// - Sample clock from internal or external sources
// - Engine makes sample clock unless external
// - Start trigger runs; hardware/software stops finite
// - Start delay in timebase ticks, default two
// - Sample clock divided from selectable timebase
// - Timebase never exported to any terminal
// - Software start when no trigger configured
// - Retrigger gives full count every trigger
// - Ignore triggers while running, then wait
// - Digital start trigger edge selectable
// - Analog start on first comparison edge
// - Start export high pulse, clock active low
// - Pause trigger suppresses all samples
// - Pause acts from next sample only
// - Onboard clock resumes at once after pause
// - Other clocks resume on next edge after
// - Pause polarity high or low selectable, except analog
// - Analog pause while comparison event high
// - Lines undriven high-impedance during reset
// - Power-up state hiz, drive0 or drive1
// - Each active edge moves next FIFO sample
// - Retransmit replays stored samples in order
// - Pause responds to level, not edges
module dote_engine
  import dote_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration and software commands
  input wire dote_cfg_t cfg,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic underflow_clr,
  // Routing sources
  input wire logic [PFT_N-1:0] programmable_function_terminal,
  input wire logic [STB_N-1:0] system_trigger_bus_line,
  input wire logic backplane_clk10,
  input wire logic analog_event,
  input wire logic internal_clock,
  input wire logic internal_trigger,
  // Sample stream from DMA
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  // Power-up line states
  input wire logic [2*LINE_N-1:0] powerup_state,
  // Output lines
  output logic [LINE_N-1:0] line_out,
  output logic [LINE_N-1:0] line_oe,
  // Exports and status
  output logic output_start_trigger,
  output logic output_sample_clock_n,
  output logic running,
  output logic underflow
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int EXT_N = PFT_N + STB_N + 4;
  logic [EXT_N-1:0] s1_r, s2_r, s3_r, ext_r;
  wire [EXT_N-1:0] ext_raw = {analog_event, backplane_clk10, internal_clock,
                              internal_trigger, system_trigger_bus_line,
                              programmable_function_terminal};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      ext_r <= '0;
    end else begin
      s1_r <= ext_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < EXT_N; i++) begin
        if (s2_r[i] == s3_r[i]) ext_r[i] <= s3_r[i];
      end
    end
  end
  wire [PFT_N-1:0] pft = ext_r[PFT_N-1:0];
  wire [STB_N-1:0] stb = ext_r[PFT_N+STB_N-1:PFT_N];
  wire int_trig = ext_r[PFT_N+STB_N];
  wire int_clk = ext_r[PFT_N+STB_N+1];
  wire bp_clk = ext_r[PFT_N+STB_N+2];
  wire ana = ext_r[PFT_N+STB_N+3];

  function automatic logic pick(input dote_trig_sel_t s, input logic [3:0] ln,
                                input logic [PFT_N-1:0] p, input logic [STB_N-1:0] t,
                                input logic it, input logic a);
    case (s)
      TR_PFT: pick = p[ln];
      TR_STB: pick = t[ln[2:0]];
      TR_INTERNAL: pick = it;
      TR_ANALOG: pick = a;
      default: pick = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Timebase ticks
  // ------------------------------------------------------------
  logic [15:0] pre_r;
  logic tb_lvl_prev_r;
  wire [15:0] pre_last = (cfg.tb_sel == TB_20M) ? TB_20M_LAST : TB_100K_LAST;
  wire pre_tick = (pre_r == pre_last);
  logic tb_lvl;
  always_comb begin
    case (cfg.tb_sel)
      TB_BACKPLANE: tb_lvl = bp_clk;
      TB_PFT: tb_lvl = pft[cfg.tb_line];
      TB_STB: tb_lvl = stb[cfg.tb_line[2:0]];
      TB_ANALOG: tb_lvl = ana;
      default: tb_lvl = 1'b0;
    endcase
  end
  // 100 MHz maps to every core cycle: the core clock is the fastest tick
  wire tb_tick = (cfg.tb_sel == TB_100M) ? 1'b1
               : (cfg.tb_sel == TB_20M || cfg.tb_sel == TB_100K) ? pre_tick
               : (tb_lvl && !tb_lvl_prev_r);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
      tb_lvl_prev_r <= 1'b0;
    end else begin
      pre_r <= pre_tick ? '0 : pre_r + 16'h0001;
      tb_lvl_prev_r <= tb_lvl;
    end
  end

  // ------------------------------------------------------------
  // Start trigger
  // ------------------------------------------------------------
  logic trig_prev_r;
  wire trig_lvl = pick(cfg.trig_sel, cfg.trig_line, pft, stb, int_trig, ana);
  wire trig_edge = cfg.trig_falling ? (trig_prev_r && !trig_lvl)
                                    : (!trig_prev_r && trig_lvl);
  wire start_req = (cfg.trig_sel == TR_NONE) ? sw_start : trig_edge;

  // ------------------------------------------------------------
  // Pause, level sensitive
  // ------------------------------------------------------------
  wire pause_src = pick(cfg.pause_sel, cfg.pause_line, pft, stb, int_trig, ana);
  wire pause_act = (cfg.pause_sel != TR_NONE) &&
                   ((cfg.pause_low && cfg.pause_sel != TR_ANALOG) ? !pause_src
                                                                  : pause_src);

  // ------------------------------------------------------------
  // Sample clock source
  // ------------------------------------------------------------
  dote_state_t state_r, state_nxt;
  logic [DIV_W-1:0] div_r, dly_r;
  logic [CNT_W-1:0] cnt_r;
  logic sc_prev_r;
  logic sc_lvl;
  always_comb begin
    case (cfg.sc_sel)
      SC_INTERNAL: sc_lvl = int_clk;
      SC_PFT: sc_lvl = pft[cfg.sc_line];
      SC_STB: sc_lvl = stb[cfg.sc_line[2:0]];
      SC_ANALOG: sc_lvl = ana;
      default: sc_lvl = 1'b0;
    endcase
  end
  wire ext_edge = cfg.sc_falling ? (sc_prev_r && !sc_lvl) : (!sc_prev_r && sc_lvl);
  wire use_engine = (cfg.sc_sel == SC_ENGINE);
  wire div_hit = tb_tick && (div_r <= 16'h0001);
  // Onboard clock: divider simply runs, so it resumes at once after pause
  wire eng_edge = use_engine && div_hit && !pause_act;
  // Other sources resume on the first edge that lands after pause clears
  wire oth_edge = !use_engine && ext_edge && !pause_act;
  wire in_run = (state_r == ST_RUN);
  // Pause sampled only at sample boundaries, so a sample is never cut
  wire sample_tick = in_run && (eng_edge || oth_edge);
  wire last_sample = cfg.finite && (cnt_r == CNT_W'(1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_req) state_nxt = ST_DELAY;
      ST_DELAY: if (tb_tick && dly_r <= 16'h0001) state_nxt = ST_RUN;
      ST_RUN: begin
        if (sw_stop) state_nxt = ST_DONE;
        else if (sample_tick && last_sample) state_nxt = cfg.retrigger ? ST_IDLE : ST_DONE;
      end
      ST_DONE: begin
        // Software re-arms a stopped engine; with a trigger it waits in idle
        if (sw_start && cfg.trig_sel == TR_NONE) state_nxt = ST_DELAY;
        else if (sw_start) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      trig_prev_r <= 1'b0;
      sc_prev_r <= 1'b0;
      div_r <= DIVISOR_RST;
      dly_r <= START_DELAY_RST;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      trig_prev_r <= trig_lvl;
      sc_prev_r <= sc_lvl;
      if (state_r != ST_DELAY) dly_r <= cfg.start_delay;
      else if (tb_tick) dly_r <= dly_r - 16'h0001;
      if (!in_run || div_hit) div_r <= cfg.divisor;
      else if (tb_tick) div_r <= div_r - 16'h0001;
      if (state_r != ST_RUN) cnt_r <= cfg.sample_count;
      else if (sample_tick) cnt_r <= cnt_r - CNT_W'(1);
    end
  end
  assign running = in_run;

  // ------------------------------------------------------------
  // Sample FIFO and output lines
  // ------------------------------------------------------------
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  dote_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(sample_tick),
    .retransmit(cfg.retransmit)
  );

  logic [LINE_N-1:0] out_r, oe_r;
  logic underflow_r, st_pulse_r, sc_pulse_r, pu_done_r;
  wire [LINE_N-1:0] pu_drive, pu_val;
  genvar g;
  generate
    for (g = 0; g < LINE_N; g++) begin : g_pu
      assign pu_drive[g] = (powerup_state[2*g+1:2*g] != PU_HIZ);
      assign pu_val[g] = (powerup_state[2*g+1:2*g] == PU_DRIVE1);
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= '0;
      oe_r <= '0;
      pu_done_r <= 1'b0;
      underflow_r <= 1'b0;
      st_pulse_r <= 1'b0;
      sc_pulse_r <= 1'b0;
    end else begin
      pu_done_r <= 1'b1;
      if (!pu_done_r) begin
        oe_r <= pu_drive;
        out_r <= pu_val;
      end else if (sample_tick && fifo_valid) begin
        out_r <= fifo_data;
        oe_r <= '1;
      end
      // Set wins over a clear in the same cycle
      if (sample_tick && !fifo_valid) underflow_r <= 1'b1;
      else if (underflow_clr) underflow_r <= 1'b0;
      st_pulse_r <= (state_r == ST_IDLE || state_r == ST_DONE) && state_nxt == ST_DELAY;
      sc_pulse_r <= sample_tick;
    end
  end
  assign line_out = out_r;
  assign line_oe = oe_r;
  assign underflow = underflow_r;
  // Only start and sample clock leave; the timebase has no export path
  assign output_start_trigger = st_pulse_r;
  assign output_sample_clock_n = !sc_pulse_r;
endmodule // dote_engine

// >>> hw/dote_fifo.sv
`timescale 1ns/1ns
module dote_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Replay control
  input wire logic retransmit
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, rd_r, level_r, base_r;
  wire wr_go = in_valid && in_ready;
  wire rd_go = out_valid && out_ready;
  // Retransmit freezes the level, so the stored entries stay valid
  assign in_ready = (level_r != (AW+1)'(DEPTH)) && !retransmit;
  assign out_valid = (level_r != '0);
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clock) begin
    if (wr_go) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  wire [AW:0] rd_inc = (rd_r[AW-1:0] == AW'(DEPTH-1)) ? '0 : rd_r + (AW+1)'(1);
  // Replay window starts at the first unread entry, wherever the ring stands
  wire [AW:0] rd_nxt = (retransmit && rd_inc == wr_r) ? base_r : rd_inc;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      level_r <= '0;
      base_r <= '0;
    end else begin
      if (wr_go) wr_r <= (wr_r[AW-1:0] == AW'(DEPTH-1)) ? '0 : wr_r + (AW+1)'(1);
      if (rd_go) rd_r <= rd_nxt;
      if (!retransmit) base_r <= rd_go ? rd_inc : rd_r;
      if (!retransmit) level_r <= level_r + (AW+1)'(wr_go) - (AW+1)'(rd_go);
    end
  end
endmodule // dote_fifo

// >>> inc/dote_pkg.sv
package dote_pkg;

  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int DIV_W = 16;
  localparam int CNT_W = 32;
  localparam int PFT_N = 16;
  localparam int STB_N = 8;
  localparam int LINE_N = 32;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [DIV_W-1:0] START_DELAY_RST = 16'h0002;
  localparam logic [DIV_W-1:0] DIVISOR_RST = 16'h0001;
  localparam int CLK_MHZ = 125;
  localparam int TB_20M_MHZ = 20;
  localparam int TB_100K_KHZ = 100;
  localparam int TB_20M_CYC = CLK_MHZ / TB_20M_MHZ;
  localparam int TB_100K_CYC = (CLK_MHZ * 1000) / TB_100K_KHZ;
  localparam logic [15:0] TB_20M_LAST = 16'(TB_20M_CYC - 1);
  localparam logic [15:0] TB_100K_LAST = 16'(TB_100K_CYC - 1);

  // ------------------------------------------------------------
  // Source selections
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TB_100M = 3'h0,
    TB_20M = 3'h1,
    TB_100K = 3'h2,
    TB_BACKPLANE = 3'h3,
    TB_PFT = 3'h4,
    TB_STB = 3'h5,
    TB_ANALOG = 3'h6
  } dote_tb_sel_t;

  typedef enum logic [2:0] {
    SC_ENGINE = 3'h0,
    SC_INTERNAL = 3'h1,
    SC_PFT = 3'h2,
    SC_STB = 3'h3,
    SC_ANALOG = 3'h4
  } dote_sc_sel_t;

  typedef enum logic [2:0] {
    TR_NONE = 3'h0,
    TR_PFT = 3'h1,
    TR_STB = 3'h2,
    TR_INTERNAL = 3'h3,
    TR_ANALOG = 3'h4
  } dote_trig_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10,
    ST_DONE = 2'b11
  } dote_state_t;

  typedef enum logic [1:0] {
    PU_HIZ = 2'b00,
    PU_DRIVE0 = 2'b01,
    PU_DRIVE1 = 2'b10
  } dote_pu_t;

  // ------------------------------------------------------------
  // Configuration carrier
  // ------------------------------------------------------------
  typedef struct packed {
    dote_tb_sel_t tb_sel;
    logic [3:0] tb_line;
    dote_sc_sel_t sc_sel;
    logic [3:0] sc_line;
    logic sc_falling;
    logic [DIV_W-1:0] divisor;
    dote_trig_sel_t trig_sel;
    logic [3:0] trig_line;
    logic trig_falling;
    logic retrigger;
    logic [DIV_W-1:0] start_delay;
    logic finite;
    logic [CNT_W-1:0] sample_count;
    dote_trig_sel_t pause_sel;
    logic [3:0] pause_line;
    logic pause_low;
    logic retransmit;
  } dote_cfg_t;

endpackage
